// *** pms_map.svh ***
`ifndef PMS_MAP_SVH
`define PMS_MAP_SVH

// Register bus address width and byte width
`define PMS_ADDR_W 4
`define PMS_DATA_W 8

// Register offsets on the plain register port
`define PMS_OFS_CTL 4'h0
`define PMS_OFS_STP 4'h1
`define PMS_OFS_IST 4'h2
`define PMS_OFS_IMSK 4'h3

// Field positions of the power monitor control and status register
`define PMS_CTL_WFLAG 7
`define PMS_CTL_WACK 6
`define PMS_CTL_WIRQ 5
`define PMS_CTL_RSTEN 4
`define PMS_CTL_STOPEN 3
`define PMS_CTL_DETEN 2
`define PMS_CTL_BUFEN 0

// Field positions of the stop depth and threshold control register
`define PMS_STP_LVL 5
`define PMS_STP_WLVL 4
`define PMS_STP_PFLAG 3
`define PMS_STP_PACK 2
`define PMS_STP_DEPTH 0

// Field positions of the interrupt status and mask registers
`define PMS_IRQ_WARN 0
`define PMS_IRQ_DET 1
`define PMS_IRQ_WAKE 2
`define PMS_IRQ_N 3

// Reset values of the writable fields
`define PMS_RST_WIRQ 1'b0
`define PMS_RST_RSTEN 1'b1
`define PMS_RST_STOPEN 1'b1
`define PMS_RST_DETEN 1'b1
`define PMS_RST_BUFEN 1'b0
`define PMS_RST_LVL 1'b0
`define PMS_RST_WLVL 1'b0
`define PMS_RST_DEPTH 1'b0

// Synchroniser depth for the comparator levels
`define PMS_SYNC_N 2

`endif

// *** pms_pkg.sv ***
package pms_pkg;

    // One register byte
    typedef logic [7:0] pms_byte_t;

    // Result of decoding a register address
    typedef enum logic [2:0] {
        PMS_SEL_NONE,
        PMS_SEL_CTL,
        PMS_SEL_STP,
        PMS_SEL_IST,
        PMS_SEL_IMSK
    } pms_sel_t;

endpackage : pms_pkg

// *** pms_power_monitor.sv ***
// The strobed register port and the register addresses were decided locally.
`include "pms_map.svh"

// Summary of operation
// - Warning flag sets while supply is under warning level, even when already under it as reset lifts.
// - A warning acknowledge clears the flag only when the warning is gone.
// - Warning interrupt request is high while its enable and flag are set.
// - With reset enable and detection on, a detect event requests a reset.
// - Stop enable keeps detection on in stop when one, off when zero.
// - Detect enable switches detection and gates its reset and stop enables.
// - Bit 0 of the first register drives the reference buffer enable.
// - A write-once bit other than the detect level takes only its first write after each reset.
// - Detect level select locks on first write, unlocked by power-on only.
// - Second register bit 5 picks the detect level and the warning range.
// - Second register bit 4 picks the lower or higher warning level.
// - Read-only recovery flag sets on deep stop recovery, else reads zero.
// - Writing one to the recovery acknowledge clears the recovery flag.
// - Write-once stop depth bit selects shallow stop at zero, deep at one.
module pms_power_monitor (
    input wire logic clk_i, // Bus clock, 100 MHz
    input wire logic rst_n_i, // Any reset, async, active low
    input wire logic por_n_i, // Power-on reset only, async, active low
    input wire logic [`PMS_ADDR_W-1:0] addr_i, // Register address
    input wire logic [`PMS_DATA_W-1:0] wr_data_i, // Write data
    input wire logic wr_en_i, // Write strobe
    input wire logic rd_en_i, // Read strobe
    output logic [`PMS_DATA_W-1:0] rd_data_o, // Read data, next cycle
    input wire logic warn_cmp_i, // Supply below warning level, async
    input wire logic detect_cmp_i, // Supply below detect level, async
    input wire logic stop_mode_i, // Device is in stop mode
    input wire logic deep_stop_wake_i, // Pulse: recovered from deep stop
    output logic warn_irq_o, // Warning interrupt request
    output logic reset_req_o, // Undervolt reset request
    output logic ref_buf_en_o, // Reference buffer enable
    output logic stop_depth_sel_o, // 1 deep stop, 0 shallow stop
    output logic undervolt_level_sel_o, // Detect level and warning range
    output logic warning_level_sel_o, // Warning level within range
    output logic detect_active_o, // Detection is running now
    output logic irq_o // Summary interrupt, level
);

    // Register address decode, shared by the write and read paths
    function automatic pms_pkg::pms_sel_t pms_decode(
        input logic [`PMS_ADDR_W-1:0] addr
    );
        pms_pkg::pms_sel_t sel;
        sel = pms_pkg::PMS_SEL_NONE;
        case (addr)
            `PMS_OFS_CTL: sel = pms_pkg::PMS_SEL_CTL;
            `PMS_OFS_STP: sel = pms_pkg::PMS_SEL_STP;
            `PMS_OFS_IST: sel = pms_pkg::PMS_SEL_IST;
            `PMS_OFS_IMSK: sel = pms_pkg::PMS_SEL_IMSK;
            default: sel = pms_pkg::PMS_SEL_NONE;
        endcase
        return sel;
    endfunction : pms_decode

    pms_sync_if sif();

    logic warn_s;
    logic det_s;
    logic warn_s_q;
    logic det_s_q;
    pms_pkg::pms_sel_t sel;
    logic ctl_wr;
    logic stp_wr;
    logic ist_wr;
    logic imsk_wr;
    logic warn_ack;
    logic ppd_ack;
    logic warn_flag_q;
    logic warn_irq_en_q;
    logic reset_en_q;
    logic stop_en_q;
    logic detect_en_q;
    logic ref_buf_en_q;
    logic ctl_lock_q;
    logic warn_lvl_q;
    logic depth_q;
    logic stp_lock_q;
    logic lvl_q;
    logic lvl_lock_q;
    logic ppd_flag_q;
    logic detect_active;
    logic reset_req_q;
    logic [`PMS_IRQ_N-1:0] irq_evt;
    logic [`PMS_IRQ_N-1:0] irq_stat_q;
    logic [`PMS_IRQ_N-1:0] irq_mask_q;
    pms_pkg::pms_byte_t ctl_rd;
    pms_pkg::pms_byte_t stp_rd;
    pms_pkg::pms_byte_t rd_mux;
    pms_pkg::pms_byte_t rd_data_q;

    // Comparator levels cross into the bus clock before any use
    assign sif.raw = {detect_cmp_i, warn_cmp_i};

    pms_sync u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .port(sif.sync_side)
    );

    assign warn_s = sif.synced[0];
    assign det_s = sif.synced[1];

    // Strobe qualification per register
    assign sel = pms_decode(addr_i);
    assign ctl_wr = wr_en_i && (sel == pms_pkg::PMS_SEL_CTL);
    assign stp_wr = wr_en_i && (sel == pms_pkg::PMS_SEL_STP);
    assign ist_wr = wr_en_i && (sel == pms_pkg::PMS_SEL_IST);
    assign imsk_wr = wr_en_i && (sel == pms_pkg::PMS_SEL_IMSK);
    assign warn_ack = ctl_wr && wr_data_i[`PMS_CTL_WACK];
    assign ppd_ack = stp_wr && wr_data_i[`PMS_STP_PACK];

    // Delayed synced levels for edge events
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            warn_s_q <= 1'b0;
            det_s_q <= 1'b0;
        end else begin
            warn_s_q <= warn_s;
            det_s_q <= det_s;
        end
    end

    // Warning flag: a present condition re-sets it every cycle, so an
    // acknowledge only sticks once the supply has recovered
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            warn_flag_q <= 1'b0;
        end else begin
            warn_flag_q <= warn_s || (warn_flag_q && !warn_ack);
        end
    end

    // Plain read/write control bits of the first register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            warn_irq_en_q <= `PMS_RST_WIRQ;
            stop_en_q <= `PMS_RST_STOPEN;
            ref_buf_en_q <= `PMS_RST_BUFEN;
        end else if (ctl_wr) begin
            warn_irq_en_q <= wr_data_i[`PMS_CTL_WIRQ];
            stop_en_q <= wr_data_i[`PMS_CTL_STOPEN];
            ref_buf_en_q <= wr_data_i[`PMS_CTL_BUFEN];
        end
    end

    // Write-once bits of the first register; any write locks them
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reset_en_q <= `PMS_RST_RSTEN;
            detect_en_q <= `PMS_RST_DETEN;
            ctl_lock_q <= 1'b0;
        end else if (ctl_wr && !ctl_lock_q) begin
            reset_en_q <= wr_data_i[`PMS_CTL_RSTEN];
            detect_en_q <= wr_data_i[`PMS_CTL_DETEN];
            ctl_lock_q <= 1'b1;
        end
    end

    // Warning level select is plain read/write
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            warn_lvl_q <= `PMS_RST_WLVL;
        end else if (stp_wr) begin
            warn_lvl_q <= wr_data_i[`PMS_STP_WLVL];
        end
    end

    // Stop depth is write-once per reset
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            depth_q <= `PMS_RST_DEPTH;
            stp_lock_q <= 1'b0;
        end else if (stp_wr && !stp_lock_q) begin
            depth_q <= wr_data_i[`PMS_STP_DEPTH];
            stp_lock_q <= 1'b1;
        end
    end

    // Detect level select survives warm resets; only power-on clears the
    // value and its lock, so a warm reset cannot lower the trip point
    always_ff @(posedge clk_i or negedge por_n_i) begin
        if (!por_n_i) begin
            lvl_q <= `PMS_RST_LVL;
            lvl_lock_q <= 1'b0;
        end else if (stp_wr && !lvl_lock_q) begin
            lvl_q <= wr_data_i[`PMS_STP_LVL];
            lvl_lock_q <= 1'b1;
        end
    end

    // Recovery flag: a wake pulse beats an acknowledge in the same cycle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ppd_flag_q <= 1'b0;
        end else begin
            ppd_flag_q <= deep_stop_wake_i
                || (ppd_flag_q && !ppd_ack);
        end
    end

    // Detection runs when enabled, and in stop only with stop enable
    assign detect_active = detect_en_q && (!stop_mode_i || stop_en_q);

    // Reset request is registered so a comparator glitch past the
    // synchroniser cannot make a runt pulse
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reset_req_q <= 1'b0;
        end else begin
            reset_req_q <= det_s && detect_active && reset_en_q;
        end
    end

    // Sticky event bits; a new event wins over a write-one clear
    assign irq_evt[`PMS_IRQ_WARN] = warn_s && !warn_s_q;
    assign irq_evt[`PMS_IRQ_DET] = det_s && !det_s_q && detect_active;
    assign irq_evt[`PMS_IRQ_WAKE] = deep_stop_wake_i;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_stat_q <= 3'h0;
        end else if (ist_wr) begin
            irq_stat_q <= (irq_stat_q & ~wr_data_i[`PMS_IRQ_N-1:0]) | irq_evt;
        end else begin
            irq_stat_q <= irq_stat_q | irq_evt;
        end
    end

    // Interrupt mask, one bit per event
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_mask_q <= 3'h0;
        end else if (imsk_wr) begin
            irq_mask_q <= wr_data_i[`PMS_IRQ_N-1:0];
        end
    end

    // Read images; acknowledge bits and reserved bits read as zero
    always_comb begin
        ctl_rd = 8'h00;
        ctl_rd[`PMS_CTL_WFLAG] = warn_flag_q;
        ctl_rd[`PMS_CTL_WIRQ] = warn_irq_en_q;
        ctl_rd[`PMS_CTL_RSTEN] = reset_en_q;
        ctl_rd[`PMS_CTL_STOPEN] = stop_en_q;
        ctl_rd[`PMS_CTL_DETEN] = detect_en_q;
        ctl_rd[`PMS_CTL_BUFEN] = ref_buf_en_q;
        stp_rd = 8'h00;
        stp_rd[`PMS_STP_LVL] = lvl_q;
        stp_rd[`PMS_STP_WLVL] = warn_lvl_q;
        stp_rd[`PMS_STP_PFLAG] = ppd_flag_q;
        stp_rd[`PMS_STP_DEPTH] = depth_q;
    end

    // Read mux; an unmapped address reads zero
    always_comb begin
        rd_mux = 8'h00;
        case (sel)
            pms_pkg::PMS_SEL_CTL: rd_mux = ctl_rd;
            pms_pkg::PMS_SEL_STP: rd_mux = stp_rd;
            pms_pkg::PMS_SEL_IST: rd_mux = {5'h00, irq_stat_q};
            pms_pkg::PMS_SEL_IMSK: rd_mux = {5'h00, irq_mask_q};
            default: rd_mux = 8'h00;
        endcase
    end

    // Read data stand for one cycle only, zero otherwise
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_q <= 8'h00;
        end else if (rd_en_i) begin
            rd_data_q <= rd_mux;
        end else begin
            rd_data_q <= 8'h00;
        end
    end

    // Outputs
    assign rd_data_o = rd_data_q;
    assign warn_irq_o = warn_irq_en_q && warn_flag_q;
    assign reset_req_o = reset_req_q;
    assign ref_buf_en_o = ref_buf_en_q;
    assign stop_depth_sel_o = depth_q;
    assign undervolt_level_sel_o = lvl_q;
    assign warning_level_sel_o = warn_lvl_q;
    assign detect_active_o = detect_active;
    assign irq_o = |(irq_stat_q & irq_mask_q);

    // Checks on the flag, request and register behaviour
    a_sync_to_flag: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        warn_cmp_i [*3] |=> warn_flag_q
    ) else $error("warning level did not reach flag in three cycles");

    a_warn_sets: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        warn_s |=> warn_flag_q
    ) else $error("warning flag not set by present warning");

    a_warn_ack_held: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (warn_ack && warn_s) |=> warn_flag_q
    ) else $error("warning flag cleared while warning present");

    a_warn_ack_clear: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (warn_ack && !warn_s) |=> !warn_flag_q
    ) else $error("warning acknowledge did not clear the flag");

    a_warn_irq_on: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (warn_s && warn_irq_en_q && !ctl_wr) |=> warn_irq_o
    ) else $error("warning interrupt missing");

    a_reset_request: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (det_s && detect_en_q && reset_en_q && !stop_mode_i)
            |=> reset_req_o
    ) else $error("detect event did not request reset");

    a_reset_gated: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (!reset_en_q || !detect_en_q) |=> !reset_req_o
    ) else $error("reset requested while disabled");

    a_stop_gated: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (stop_mode_i && !stop_en_q) |=> !reset_req_o
    ) else $error("detection ran in stop without stop enable");

    a_bufen_follow: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        ctl_wr |=> ref_buf_en_o == $past(wr_data_i[`PMS_CTL_BUFEN])
    ) else $error("reference buffer enable did not follow write");

    a_once_locked: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (ctl_lock_q && ctl_wr) |=>
            $stable(reset_en_q) && $stable(detect_en_q)
    ) else $error("write-once bit changed after lock");

    a_level_locked: assert property (
        @(posedge clk_i) disable iff (!por_n_i)
        (lvl_lock_q && stp_wr) |=> $stable(undervolt_level_sel_o)
    ) else $error("detect level changed after lock");

    a_ppd_sets: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        deep_stop_wake_i |=> ppd_flag_q
    ) else $error("recovery flag not set by wake");

    a_ppd_clears: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        (ppd_ack && !deep_stop_wake_i) |=> !ppd_flag_q
    ) else $error("recovery acknowledge did not clear flag");

    a_read_once: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        !rd_en_i |=> rd_data_o == 8'h00
    ) else $error("read data present without a read");

endmodule : pms_power_monitor

// *** pms_power_monitor_tb_top.sv ***
`include "pms_map.svh"

module pms_power_monitor_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic por_n_i = 1'b0;
    logic [`PMS_ADDR_W-1:0] addr_i = 4'h0;
    logic [`PMS_DATA_W-1:0] wr_data_i = 8'h00;
    logic wr_en_i = 1'b0;
    logic rd_en_i = 1'b0;
    logic [`PMS_DATA_W-1:0] rd_data_o;
    logic warn_cmp_i = 1'b0;
    logic detect_cmp_i = 1'b0;
    logic stop_mode_i = 1'b0;
    logic deep_stop_wake_i = 1'b0;
    logic warn_irq_o;
    logic reset_req_o;
    logic ref_buf_en_o;
    logic stop_depth_sel_o;
    logic undervolt_level_sel_o;
    logic warning_level_sel_o;
    logic detect_active_o;
    logic irq_o;
    logic [7:0] outs;
    int miscompares = 0;
    int checks_done = 0;

    // Output image: b6 irq req, b5 reset req, b4 buffer, b3 depth,
    // b2 detect level, b1 warning level, b0 detection running
    assign outs = {1'b0, warn_irq_o, reset_req_o, ref_buf_en_o,
                   stop_depth_sel_o, undervolt_level_sel_o,
                   warning_level_sel_o, detect_active_o};

    pms_power_monitor pms_power_monitor_inst (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .por_n_i(por_n_i),
        .addr_i(addr_i),
        .wr_data_i(wr_data_i),
        .wr_en_i(wr_en_i),
        .rd_en_i(rd_en_i),
        .rd_data_o(rd_data_o),
        .warn_cmp_i(warn_cmp_i),
        .detect_cmp_i(detect_cmp_i),
        .stop_mode_i(stop_mode_i),
        .deep_stop_wake_i(deep_stop_wake_i),
        .warn_irq_o(warn_irq_o),
        .reset_req_o(reset_req_o),
        .ref_buf_en_o(ref_buf_en_o),
        .stop_depth_sel_o(stop_depth_sel_o),
        .undervolt_level_sel_o(undervolt_level_sel_o),
        .warning_level_sel_o(warning_level_sel_o),
        .detect_active_o(detect_active_o),
        .irq_o(irq_o)
    );

    // 100 MHz bus clock
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h expected %h", $time,
                     seen, exp);
        end
    endtask : chk

    // Waits n edges, then lets that edge's updates settle
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick

    // Power-on reset also clears the level lock; plain reset does not
    task automatic do_reset(input logic por);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        por_n_i <= ~por;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        por_n_i <= 1'b1;
        tick(1);
    endtask : do_reset

    // One-cycle write strobe; the slave never stalls
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_en_i <= 1'b1;
        addr_i <= a;
        wr_data_i <= d;
        @(posedge clk_i);
        wr_en_i <= 1'b0;
        #1;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        rd_en_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_en_i <= 1'b0;
        #1;
        chk(rd_data_o, exp);
    endtask : rd

    task automatic t_reset_vals;
        rd(`PMS_OFS_CTL, 8'h1c);
        rd(`PMS_OFS_STP, 8'h00);
        rd(4'h5, 8'h00);
        chk(outs, 8'h01);
        chk({7'h00, irq_o}, 8'h00);
    endtask : t_reset_vals

    task automatic t_lock;
        wr(`PMS_OFS_CTL, 8'h1d);
        chk(outs, 8'h11);
        wr(`PMS_OFS_CTL, 8'h00);
        rd(`PMS_OFS_CTL, 8'h14);
        chk(outs, 8'h01);
    endtask : t_lock

    task automatic t_warn;
        @(posedge clk_i);
        warn_cmp_i <= 1'b1;
        tick(4);
        rd(`PMS_OFS_CTL, 8'h94);
        chk(outs, 8'h01);
        // Acknowledge while the warning persists must not clear it
        wr(`PMS_OFS_CTL, 8'h60);
        rd(`PMS_OFS_CTL, 8'hb4);
        chk(outs, 8'h41);
        rd(`PMS_OFS_IST, 8'h01);
        chk({7'h00, irq_o}, 8'h00);
        wr(`PMS_OFS_IMSK, 8'h01);
        chk({7'h00, irq_o}, 8'h01);
        @(posedge clk_i);
        warn_cmp_i <= 1'b0;
        tick(3);
        wr(`PMS_OFS_CTL, 8'h60);
        rd(`PMS_OFS_CTL, 8'h34);
        chk(outs, 8'h01);
        wr(`PMS_OFS_IST, 8'h01);
        chk({7'h00, irq_o}, 8'h00);
        rd(`PMS_OFS_IST, 8'h00);
    endtask : t_warn

    task automatic t_detect;
        @(posedge clk_i);
        stop_mode_i <= 1'b1;
        tick(1);
        chk(outs, 8'h00);
        @(posedge clk_i);
        detect_cmp_i <= 1'b1;
        tick(5);
        chk(outs, 8'h00);
        rd(`PMS_OFS_IST, 8'h00);
        wr(`PMS_OFS_CTL, 8'h28);
        chk({7'h00, outs[0]}, 8'h01);
        tick(2);
        chk(outs, 8'h21);
        @(posedge clk_i);
        stop_mode_i <= 1'b0;
        detect_cmp_i <= 1'b0;
        tick(4);
        chk(outs, 8'h01);
        // A detect rise while detection runs leaves a sticky event
        @(posedge clk_i);
        detect_cmp_i <= 1'b1;
        tick(4);
        rd(`PMS_OFS_IST, 8'h02);
        chk(outs, 8'h21);
        @(posedge clk_i);
        detect_cmp_i <= 1'b0;
        tick(4);
        wr(`PMS_OFS_IST, 8'h02);
        rd(`PMS_OFS_IST, 8'h00);
    endtask : t_detect

    task automatic t_thresh;
        wr(`PMS_OFS_STP, 8'h31);
        chk(outs, 8'h0f);
        wr(`PMS_OFS_STP, 8'h00);
        chk(outs, 8'h0d);
        rd(`PMS_OFS_STP, 8'h21);
        // Warning already present when reset lifts
        @(posedge clk_i);
        warn_cmp_i <= 1'b1;
        do_reset(1'b0);
        tick(4);
        rd(`PMS_OFS_CTL, 8'h9c);
        chk(outs, 8'h05);
        // Init writes both registers even where the defaults already hold
        wr(`PMS_OFS_STP, 8'h00);
        chk(outs, 8'h05);
        wr(`PMS_OFS_STP, 8'h01);
        chk(outs, 8'h05);
        wr(`PMS_OFS_CTL, 8'h00);
        @(posedge clk_i);
        detect_cmp_i <= 1'b1;
        tick(5);
        chk(outs, 8'h04);
        @(posedge clk_i);
        detect_cmp_i <= 1'b0;
        warn_cmp_i <= 1'b0;
        do_reset(1'b1);
        chk(outs, 8'h01);
        wr(`PMS_OFS_STP, 8'h20);
        chk(outs, 8'h05);
    endtask : t_thresh

    task automatic t_recover;
        @(posedge clk_i);
        deep_stop_wake_i <= 1'b1;
        @(posedge clk_i);
        deep_stop_wake_i <= 1'b0;
        rd(`PMS_OFS_STP, 8'h28);
        rd(`PMS_OFS_IST, 8'h04);
        wr(`PMS_OFS_IMSK, 8'h04);
        chk({7'h00, irq_o}, 8'h01);
        wr(`PMS_OFS_STP, 8'h24);
        rd(`PMS_OFS_STP, 8'h20);
        wr(`PMS_OFS_IST, 8'h04);
        chk({7'h00, irq_o}, 8'h00);
    endtask : t_recover

    task automatic end_sim;
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    // Whole sequence needs well under a thousand cycles
    initial begin
        #100000;
        miscompares++;
        end_sim();
    end

    initial begin
        do_reset(1'b1);
        t_reset_vals();
        t_lock();
        t_warn();
        t_detect();
        t_thresh();
        t_recover();
        end_sim();
    end
endmodule : pms_power_monitor_tb_top

// *** pms_sync.sv ***
`include "pms_map.svh"

module pms_sync (
    input wire logic clk_i, // Bus clock
    input wire logic rst_n_i, // Asynchronous reset, active low
    pms_sync_if.sync_side port // Raw levels in, synced levels out
);

    logic [1:0] meta_q;
    logic [1:0] sync_q;

    // Two flops; the first is read by the second only, so a metastable
    // level never reaches the flag logic
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= 2'h0;
            sync_q <= 2'h0;
        end else begin
            meta_q <= port.raw;
            sync_q <= meta_q;
        end
    end

    assign port.synced = sync_q;

endmodule : pms_sync

// *** pms_sync_if.sv ***
// Comparator levels before and after the crossing into the bus clock
interface pms_sync_if;
    logic [1:0] raw;
    logic [1:0] synced;

    modport sync_side (
        input raw,
        output synced
    );

    modport user_side (
        output raw,
        input synced
    );
endinterface : pms_sync_if
